// file: anp_pkg.sv
// Shared constants and types for the next page register bank
package anp_pkg;

  // Register offsets in the auto-negotiation device space
  localparam logic [15:0] OFF_LP_BASE3 = 16'h0015;
  localparam logic [15:0] OFF_TX_NP1   = 16'h0016;
  localparam logic [15:0] OFF_TX_NP2   = 16'h0017;
  localparam logic [15:0] OFF_TX_NP3   = 16'h0018;
  localparam logic [15:0] OFF_LP_NP1   = 16'h0019;

  // Values after reset
  localparam logic [15:0] RST_LP_BASE3 = 16'h0000;
  localparam logic [15:0] RST_TX_NP1   = 16'h2000;
  localparam logic [15:0] RST_TX_NP2   = 16'h0000;
  localparam logic [15:0] RST_TX_NP3   = 16'h0000;
  localparam logic [15:0] RST_LP_NP1   = 16'h0000;

  // Field positions in a next page word and in the third base page word
  localparam int unsigned BIT_MORE     = 15;
  localparam int unsigned BIT_ACK      = 14;
  localparam int unsigned BIT_MSG      = 13;
  localparam int unsigned BIT_CAN_ACT  = 12;
  localparam int unsigned BIT_TOGGLE   = 11;
  localparam int unsigned CODE_MSB     = 10;
  localparam int unsigned BIT_FEC_REQ  = 15;
  localparam int unsigned BIT_FEC_CAP  = 14;
  localparam int unsigned TECH_MSB     = 13;

  // Management serial frame layout
  localparam logic [4:0] DEVAD_AN      = 5'h07;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] HDR_LAST      = 5'h0d;
  localparam logic [4:0] TA_DRIVE      = 5'h0f;
  localparam logic [4:0] FRAME_LAST    = 5'h1f;
  localparam logic [1:0] OP_ADDR       = 2'h0;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_RDINC      = 2'h2;
  localparam logic [1:0] OP_READ       = 2'h3;
  localparam int unsigned SYNC_STAGES  = 2;

  // 48-bit page code word, high word carries D47:D32
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] mid;
    logic [15:0] low;
  } anp_page_t;

  // Management pins after synchronisation
  typedef struct packed {
    logic       mdc;
    logic       mdio;
    logic [4:0] port;
  } anp_pins_t;

endpackage

// file: anp_sync.sv
// Two-flop synchroniser for management pins entering the system clock domain
module anp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import anp_pkg::*;

  logic [WIDTH-1:0] stage1_r;

  // First stage is read by the second stage only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      dout     <= '0;
    end else begin
      stage1_r <= din;
      dout     <= stage1_r;
    end
  end

endmodule

// file: anp_np_hold.sv
// Holds the upper words of the received next page from the last low word read
module anp_np_hold (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              lowWordRead,
  input  wire anp_pkg::anp_page_t rxPage,
  output logic      [31:0]       upperHold
);
  import anp_pkg::*;

  // freeze upper words
  // Later reads of the upper words see the page of the low word read,
  // even if a new page lands in between
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      upperHold <= 32'h0000_0000;
    end else if (lowWordRead) begin
      upperHold <= {rxPage.high, rxPage.mid};
    end
  end

  chk_hold_capture: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lowWordRead |=> upperHold == $past({rxPage.high, rxPage.mid}))
    else $error("upper words not captured on low word read");

  chk_hold_stable: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lowWordRead |=> $stable(upperHold))
    else $error("upper words changed without low word read");

endmodule

// file: anp_regs.sv
// Next page register bank with management serial slave
import anp_pkg::*;

// Contract
// - Bit 15 of the partner base page word 3 shows received base page bit D47.
// - Bit 14 of the partner base page word 3 shows received base page bit D46.
// - Bits 13:0 of the partner base page word 3 show received base page bits D45:D32.
// - Transmit next page word 1 bit 15, reset 0, is sent as next page bit D15.
// - Transmit next page word 1 bit 13, reset 1, drives next page bit D13.
// - Transmit next page word 1 bit 12, reset 0, drives next page bit D12.
// - The sent toggle bit is made in hardware; bit 11 only stores what was written.
// - Transmit next page word 1 bits 10:0, reset 0, drive next page bits D10:D0.
// - Transmit next page word 2, reset 0, drives next page bits D31:D16.
// - Transmit next page word 3, reset 0, drives next page bits D47:D32.
// - Partner next page word 1 bits 15 and 13 show D15 and D13, reset 0.
// - Partner next page word 1 bit 14 shows D14, reset 0.
// - Partner next page word 1 bit 12 shows D12.
// - Partner next page word 1 bit 11 shows the toggle D11 of the latest page.
// - Partner next page word 1 bits 10:0 show D10:D0.
module anp_regs (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               mdc,
  input  wire logic               mdioIn,
  output logic                    mdioOut,
  output logic                    mdioOe,
  input  wire logic [4:0]         portAddr,
  input  wire logic               lpBaseValid,
  input  wire anp_pkg::anp_page_t lpBasePage,
  input  wire logic               lpNextValid,
  input  wire anp_pkg::anp_page_t lpNextPage,
  input  wire logic               txPageSent,
  output anp_pkg::anp_page_t      txNextPage,
  output logic [31:0]             rxNpUpperHold
);
  import anp_pkg::*;

  typedef enum logic [0:0] {MD_PRE, MD_FRAME} anp_mdst_t;

  anp_pins_t   pinsRaw;
  anp_pins_t   pinsS;
  anp_mdst_t   st_r;
  logic        mdcPrev_r;
  logic        mdcRise;
  logic        mdcFall;
  logic [5:0]  onesCnt_r;
  logic [4:0]  bitCnt_r;
  logic [15:0] shift_r;
  logic [12:0] hdr;
  logic [15:0] frameData;
  logic [1:0]  op_r;
  logic        hit_r;
  logic        hdrDone;
  logic        frameDone;
  logic [15:0] regAddr_r;
  logic [15:0] rdData_r;
  logic        wrStrobe;
  logic        lowWordRead;
  logic [15:0] lpBase3_r;
  logic [15:0] txW1_r;
  logic [15:0] txW2_r;
  logic [15:0] txW3_r;
  logic [15:0] lpNp1_r;
  logic        toggle_r;

  assign pinsRaw = '{mdc: mdc, mdio: mdioIn, port: portAddr};

  anp_sync #(
    .WIDTH ($bits(anp_pins_t))
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (pinsRaw),
    .dout    (pinsS)
  );

  // Clock edges of the management clock, seen after synchronisation
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mdcPrev_r <= 1'b0;
    end else begin
      mdcPrev_r <= pinsS.mdc;
    end
  end

  assign mdcRise   = pinsS.mdc & ~mdcPrev_r;
  assign mdcFall   = ~pinsS.mdc & mdcPrev_r;
  assign hdr       = {shift_r[11:0], pinsS.mdio};
  assign frameData = {shift_r[14:0], pinsS.mdio};
  assign hdrDone   = mdcRise && (st_r == MD_FRAME) && (bitCnt_r == HDR_LAST);
  assign frameDone = mdcRise && (st_r == MD_FRAME) && (bitCnt_r == FRAME_LAST);
  assign wrStrobe  = frameDone && hit_r && (op_r == OP_WRITE);

  function automatic logic [15:0] regRead(input logic [15:0] addr);
    case (addr)
      OFF_LP_BASE3: regRead = lpBase3_r;
      OFF_TX_NP1:   regRead = txW1_r;
      OFF_TX_NP2:   regRead = txW2_r;
      OFF_TX_NP3:   regRead = txW3_r;
      OFF_LP_NP1:   regRead = lpNp1_r;
      default:      regRead = 16'h0000;
    endcase
  endfunction

  // Frame sequencer: preamble of ones, then 32 bits of header, turnaround and data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r      <= MD_PRE;
      onesCnt_r <= 6'h00;
      bitCnt_r  <= 5'h00;
      shift_r   <= 16'h0000;
    end else if (mdcRise) begin
      case (st_r)
        MD_PRE: begin
          if (pinsS.mdio) begin
            if (onesCnt_r != PREAMBLE_BITS) begin
              onesCnt_r <= onesCnt_r + 6'h01;
            end
          end else if (onesCnt_r == PREAMBLE_BITS) begin
            st_r     <= MD_FRAME;
            bitCnt_r <= 5'h01;
            shift_r  <= 16'h0000;
          end else begin
            onesCnt_r <= 6'h00;
          end
        end
        MD_FRAME: begin
          shift_r  <= frameData;
          bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == FRAME_LAST) begin
            st_r      <= MD_PRE;
            onesCnt_r <= 6'h00;
            bitCnt_r  <= 5'h00;
          end
        end
        default: begin
          st_r      <= MD_PRE;
          onesCnt_r <= 6'h00;
        end
      endcase
    end
  end

  // Header decode: second start bit low, our port, auto-negotiation device
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_r  <= OP_ADDR;
      hit_r <= 1'b0;
    end else if (hdrDone) begin
      op_r  <= hdr[11:10];
      hit_r <= !hdr[12] && (hdr[9:5] == pinsS.port) && (hdr[4:0] == DEVAD_AN);
    end else if (frameDone) begin
      hit_r <= 1'b0;
    end
  end

  // Address register; post-read-increment steps it at frame end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regAddr_r <= 16'h0000;
    end else if (frameDone && hit_r) begin
      if (op_r == OP_ADDR) begin
        regAddr_r <= frameData;
      end else if (op_r == OP_RDINC) begin
        regAddr_r <= regAddr_r + 16'h0001;
      end
    end
  end

  // Read data is sampled at header end so it cannot tear during the shift-out
  assign lowWordRead = hdrDone && !hdr[12] && hdr[11] && (hdr[9:5] == pinsS.port)
                       && (hdr[4:0] == DEVAD_AN) && (regAddr_r == OFF_LP_NP1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_r <= 16'h0000;
    end else if (hdrDone) begin
      rdData_r <= regRead(regAddr_r);
    end
  end

  // Pin is changed on the falling clock so the host samples it settled on the rise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
    end else if (mdcFall) begin
      mdioOe  <= (st_r == MD_FRAME) && hit_r && op_r[1] && (bitCnt_r >= TA_DRIVE);
      mdioOut <= (bitCnt_r > TA_DRIVE) ? rdData_r[~bitCnt_r[3:0]] : 1'b0;
    end
  end

  // transmit word 1
  // Bit 14 is held at zero so it always reads back as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txW1_r <= RST_TX_NP1;
    end else if (wrStrobe && regAddr_r == OFF_TX_NP1) begin
      txW1_r <= frameData & ~(16'h0001 << BIT_ACK);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txW2_r <= RST_TX_NP2;
      txW3_r <= RST_TX_NP3;
    end else if (wrStrobe) begin
      if (regAddr_r == OFF_TX_NP2) begin
        txW2_r <= frameData;
      end
      if (regAddr_r == OFF_TX_NP3) begin
        txW3_r <= frameData;
      end
    end
  end

  // hardware toggle
  // Flips once per page the engine sends; the stored bit 11 never reaches the line
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
    end else if (txPageSent) begin
      toggle_r <= ~toggle_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txNextPage <= '{high: RST_TX_NP3, mid: RST_TX_NP2, low: RST_TX_NP1};
    end else begin
      txNextPage.high <= txW3_r;
      txNextPage.mid  <= txW2_r;
      txNextPage.low  <= {txW1_r[15:12], toggle_r, txW1_r[CODE_MSB:0]};
    end
  end

  // partner base word 3
  // Only the engine loads it; management writes have no path here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lpBase3_r <= RST_LP_BASE3;
    end else if (lpBaseValid) begin
      lpBase3_r <= lpBasePage.high;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lpNp1_r <= RST_LP_NP1;
    end else if (lpNextValid) begin
      lpNp1_r <= lpNextPage.low;
    end
  end

  anp_np_hold u_hold (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .lowWordRead (lowWordRead),
    .rxPage      (lpNextPage),
    .upperHold   (rxNpUpperHold)
  );

  chk_fec_request: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpBaseValid |=> lpBase3_r[BIT_FEC_REQ] == $past(lpBasePage.high[BIT_FEC_REQ]))
    else $error("partner FEC request bit not captured");

  chk_fec_capable: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpBaseValid |=> lpBase3_r[BIT_FEC_CAP] == $past(lpBasePage.high[BIT_FEC_CAP]))
    else $error("partner FEC ability bit not captured");

  chk_tech_upper: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpBaseValid ##1 !lpBaseValid [*2] |->
      lpBase3_r[TECH_MSB:0] == $past(lpBasePage.high[TECH_MSB:0], 2))
    else $error("partner technology field lost");

  chk_tx_more: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(txW1_r[BIT_MORE]) |=> txNextPage.low[BIT_MORE])
    else $error("next page flag not sent");

  chk_tx_msg: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> txNextPage.low[BIT_MSG] == $past(txW1_r[BIT_MSG]))
    else $error("message page flag not sent");

  chk_tx_can_act: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(txW1_r[BIT_CAN_ACT]) |=> txNextPage.low[BIT_CAN_ACT] == $past(txW1_r[BIT_CAN_ACT]))
    else $error("can-act bit not sent");

  chk_toggle_flip: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    txPageSent && !$past(txPageSent) |=> ##1 txNextPage.low[BIT_TOGGLE] != $past(toggle_r, 2))
    else $error("toggle did not flip after a sent page");

  chk_tx_code: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrStrobe && regAddr_r == OFF_TX_NP1 |-> ##2 txNextPage.low[CODE_MSB:0] == $past(frameData[CODE_MSB:0], 2))
    else $error("written code field not sent");

  chk_tx_mid: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrStrobe && regAddr_r == OFF_TX_NP2 |-> ##2 txNextPage.mid == $past(frameData, 2))
    else $error("written word 2 not sent");

  chk_tx_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrStrobe && regAddr_r == OFF_TX_NP3 |-> ##2 txNextPage.high == $past(frameData, 2))
    else $error("written word 3 not sent");

  chk_rx_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpNextValid |=> lpNp1_r[BIT_MORE] == $past(lpNextPage.low[BIT_MORE])
      && lpNp1_r[BIT_MSG] == $past(lpNextPage.low[BIT_MSG]))
    else $error("partner next page flags not captured");

  chk_rx_ack: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpNextValid |=> lpNp1_r[BIT_ACK] == $past(lpNextPage.low[BIT_ACK]))
    else $error("partner acknowledge bit not captured");

  chk_rx_can_act: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpNextValid |=> lpNp1_r[BIT_CAN_ACT] == $past(lpNextPage.low[BIT_CAN_ACT]))
    else $error("partner can-act bit not captured");

  chk_rx_toggle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpNextValid |=> lpNp1_r[BIT_TOGGLE] == $past(lpNextPage.low[BIT_TOGGLE]))
    else $error("partner toggle not captured");

  chk_rx_code: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lpNextValid |=> lpNp1_r[CODE_MSB:0] == $past(lpNextPage.low[CODE_MSB:0]))
    else $error("partner code field not captured");

  chk_ro_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lpNextValid && !lpBaseValid |=> $stable(lpNp1_r) && $stable(lpBase3_r))
    else $error("read-only word changed without a received page");

endmodule

// file: anp_regs_tb.sv
// Self-checking bench for the next page register bank
module anp_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import anp_pkg::*;

  logic        sys_clk;
  logic        rst_n;
  logic        mdc;
  logic        mdoDrv;
  logic [4:0]  portAddr;
  logic        lpBaseValid;
  logic        lpNextValid;
  logic        txPageSent;
  anp_page_t   lpBasePage;
  anp_page_t   lpNextPage;
  anp_page_t   txNextPage;
  anp_page_t   pg;
  anp_page_t   pg2;
  logic        mdioOut;
  logic        mdioOe;
  logic [31:0] rxNpUpperHold;
  logic [15:0] expW1;
  logic [15:0] expW2;
  logic [15:0] expW3;
  logic [15:0] rdv;
  logic        expTog;
  integer      error_cnt;
  integer      n_compared;
  integer      seed;
  integer      k;
  // Released line floats high through the pull-up, so mdoDrv idles at 1
  wire logic   mdioWire = mdioOe ? mdioOut : mdoDrv;

  anp_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioWire),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .portAddr(portAddr), .lpBaseValid(lpBaseValid),
    .lpBasePage(lpBasePage), .lpNextValid(lpNextValid), .lpNextPage(lpNextPage),
    .txPageSent(txPageSent), .txNextPage(txNextPage), .rxNpUpperHold(rxNpUpperHold));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tick();
    @(posedge sys_clk);
    #10;
  endtask

  task automatic close_out();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One serial frame, MSB first; mdc half period of 4 cycles, data sampled before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b00, op, prt, dev, op[1] ? 2'b11 : 2'b10,
         op[1] ? 16'hffff : wdata};
    rdata = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdc = 1'b0;
      mdoDrv = f[i];
      repeat (4) tick();
      if (i < 16) rdata[i] = mdioWire;
      mdc = 1'b1;
      repeat (4) tick();
    end
    mdc = 1'b0;
    mdoDrv = 1'b1;
    repeat (6) tick();
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    logic [15:0] d;
    frame(OP_ADDR, portAddr, DEVAD_AN, addr, d);
    frame(OP_WRITE, portAddr, DEVAD_AN, data, d);
  endtask

  task automatic rchk(input logic [15:0] addr, input logic [15:0] exp, input string what);
    logic [15:0] d;
    frame(OP_ADDR, portAddr, DEVAD_AN, addr, d);
    frame(OP_READ, portAddr, DEVAD_AN, 16'h0000, d);
    chk({32'h0000_0000, d}, {32'h0000_0000, exp}, what);
  endtask

  // Outgoing page from the model: bit 11 is the hardware toggle, bit 14 is left unchecked
  function automatic logic [47:0] txExp();
    return {expW3, expW2, expW1[15], 1'b0, expW1[13:12], expTog, expW1[10:0]};
  endfunction

  task automatic txChk();
    chk(txNextPage & 48'hffff_ffff_bfff, txExp(), "tx page");
  endtask

  task automatic doReset();
    rst_n = 1'b0;
    repeat (3) tick();
    expW1 = RST_TX_NP1;
    expW2 = RST_TX_NP2;
    expW3 = RST_TX_NP3;
    expTog = 1'b0;
    rst_n = 1'b1;
    repeat (4) tick();
    txChk();
    chk({46'h0, mdioOe, mdioOut}, 48'h0, "pin idle after reset");
    chk({16'h0000, rxNpUpperHold}, 48'h0, "hold reset");
    rchk(OFF_LP_BASE3, RST_LP_BASE3, "base3 reset");
    rchk(OFF_TX_NP1, RST_TX_NP1, "np1 reset");
    rchk(OFF_TX_NP2, RST_TX_NP2, "np2 reset");
    rchk(OFF_TX_NP3, RST_TX_NP3, "np3 reset");
    rchk(OFF_LP_NP1, RST_LP_NP1, "lp np1 reset");
  endtask

  task automatic pulse(input int which);
    if (which == 0) lpBaseValid = 1'b1;
    else if (which == 1) lpNextValid = 1'b1;
    else txPageSent = 1'b1;
    tick();
    lpBaseValid = 1'b0;
    lpNextValid = 1'b0;
    txPageSent = 1'b0;
    repeat (3) tick();
  endtask

  initial begin
    repeat (70000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    seed = 32'h9689;
    rst_n = 1'b0;
    mdc = 1'b0;
    mdoDrv = 1'b1;
    lpBaseValid = 1'b0;
    lpNextValid = 1'b0;
    txPageSent = 1'b0;
    lpBasePage = '0;
    lpNextPage = '0;
    portAddr = 5'($random(seed));
    doReset();
    // Transmit words, words 1 and 2 all-ones first so bit 14 masking and bit 11 storage are seen
    for (k = 0; k < 3; k++) begin
      expW1 = (k == 0) ? 16'hffff : 16'($random(seed));
      expW2 = (k == 0) ? 16'hffff : 16'($random(seed));
      expW3 = (k == 2) ? 16'h0001 : 16'($random(seed));
      wr(OFF_TX_NP1, expW1);
      wr(OFF_TX_NP2, expW2);
      wr(OFF_TX_NP3, expW3);
      txChk();
      rchk(OFF_TX_NP1, expW1 & 16'hbfff, "np1 readback");
      rchk(OFF_TX_NP3, expW3, "np3 readback");
    end
    // Read with increment then plain read walks from word 1 to word 2
    frame(OP_ADDR, portAddr, DEVAD_AN, OFF_TX_NP1, rdv);
    frame(OP_RDINC, portAddr, DEVAD_AN, 16'h0000, rdv);
    chk({32'h0, rdv}, {32'h0, expW1 & 16'hbfff}, "rdinc np1");
    frame(OP_READ, portAddr, DEVAD_AN, 16'h0000, rdv);
    chk({32'h0, rdv}, {32'h0, expW2}, "after inc np2");
    for (k = 0; k < 2; k++) begin
      pulse(2);
      expTog = ~expTog;
      txChk();
    end
    rchk(OFF_TX_NP1, expW1 & 16'hbfff, "toggle not stored");
    for (k = 0; k < 2; k++) begin
      lpBasePage = 48'({$random(seed), $random(seed)});
      if (k == 0) lpBasePage.high = 16'h8000;
      pg = lpBasePage;
      pulse(0);
      lpBasePage = '0;
      rchk(OFF_LP_BASE3, pg.high, "base3");
      wr(OFF_LP_BASE3, 16'h5a5a);
      rchk(OFF_LP_BASE3, pg.high, "base3 kept");
    end
    lpBasePage = {16'h4abc, 32'h0};
    pulse(0);
    lpBasePage = 48'({$random(seed), $random(seed)});
    wr(OFF_LP_BASE3, 16'hffff);
    rchk(OFF_LP_BASE3, 16'h4abc, "base3 after write");
    for (k = 0; k < 2; k++) begin
      pg = 48'({$random(seed), $random(seed)});
      if (k == 0) pg.low = 16'haaaa;
      pg2 = ~pg;
      lpNextPage = pg;
      pulse(1);
      rchk(OFF_LP_NP1, pg.low, "lp np1");
      chk({16'h0, rxNpUpperHold}, {16'h0, pg.high, pg.mid}, "hold");
      lpNextPage = pg2;
      pulse(1);
      chk({16'h0, rxNpUpperHold}, {16'h0, pg.high, pg.mid}, "hold kept");
      wr(OFF_LP_NP1, pg.low);
      rchk(OFF_LP_NP1, pg2.low, "lp np1 new");
      chk({16'h0, rxNpUpperHold}, {16'h0, pg2.high, pg2.mid}, "hold new");
    end
    wr(16'h001c, 16'h1234);
    rchk(16'h001c, 16'h0000, "unmapped");
    // Foreign port or device: frame ignored, so the line stays at its pull-up level
    frame(OP_ADDR, portAddr, DEVAD_AN, OFF_TX_NP2, rdv);
    frame(OP_READ, portAddr ^ 5'h01, DEVAD_AN, 16'h0000, rdv);
    chk({32'h0, rdv}, {32'h0, 16'hffff}, "wrong port read");
    frame(OP_READ, portAddr, 5'h01, 16'h0000, rdv);
    chk({32'h0, rdv}, {32'h0, 16'hffff}, "wrong device read");
    frame(OP_WRITE, portAddr ^ 5'h10, DEVAD_AN, 16'h0f0f, rdv);
    rchk(OFF_TX_NP2, expW2, "wrong port write");
    pulse(2);
    doReset();
    close_out();
  end
endmodule
